// ===== rtl/nim_arbiter.sv
// nim_arbiter: picks the request to serve from pending latches
// assumes index 0 has highest fixed rank, higher index lower rank
`timescale 1ns/100ps
`default_nettype none
module nim_arbiter #(
    parameter int N = 14
) (
    input wire logic [N-1:0] pend,
    input wire logic [2*N-1:0] lvl_flat,
    input wire logic [N-1:0] wake_cap,
    input wire logic halt_only,
    input wire logic block,
    input wire logic [1:0] cur_lvl,
    output logic found,
    output logic [3:0] idx,
    output logic [1:0] lvl
);
    logic [N-1:0] cand;

    always_comb
    begin
        cand = pend & (halt_only ? wake_cap : {N{1'b1}}); // R16
        found = 1'b0;
        idx = '0;
        lvl = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            // walk from lowest rank up so equal levels go to higher rank
            if (cand[i] && !block && (lvl_flat[2*i +: 2] > cur_lvl)) // R24
            begin
                if (!found || (lvl_flat[2*i +: 2] >= lvl)) // R19
                begin
                    found = 1'b1;
                    idx = 4'(i);
                    lvl = lvl_flat[2*i +: 2];
                end
            end
        end
    end
endmodule // nim_arbiter
`default_nettype wire

// ===== rtl/nim_manager.sv
// nim_manager: nested interrupt manager beside an 8-bit core, apb registers
// assumes core reports instruction ends and stack pops in cpu_evt, holds cpu_ctx
// Contract
// R01: four programmable nesting levels
// R02: sixteen vectors fixed to sources
// R03: reset and trap unmaskable, top-level maskable
// R04: vectors from ffe0 to ffff by rank
// R05: mask with cc bits five and three
// R06: finish current instruction before entry
// R07: push pc, x, a, cc on entry
// R08: entry loads priority bits from vector setting
// R09: load pc from vector, then fetch
// R10: return restores priority bits from stack
// R11: request needs status flag and enable
// R12: software clears via status then data access
// R13: clear sequence drops pending request
// R14: any interrupt leaves wait mode
// R15: only wake-capable sources leave halt
// R16: halt exit picks among wake-capable only
// R17: non-wake request served after first
// R18: concurrent blocks preemption, nested allows higher
// R19: fixed rank main lowest, top-level highest
// R20: halt opcode 8e unmasks interrupts
// R21: no stack overflow detection
// R22: level codes 10, 01, 00, 11
// R23: mask instructions also write priority bits
// R24: highest level wins, rank breaks ties
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module nim_manager #(
    parameter int NSRC = 13,
    parameter logic [12:0] HALT_WAKE_MASK = 13'h000f
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NSRC-1:0] irq_flag,
    input wire logic [NSRC-1:0] irq_enable,
    input wire logic [NSRC-1:0] irq_clear,
    input wire logic top_level_irq,
    input wire logic top_level_clear,
    input wire nim_pkg::nim_cpu_evt_type cpu_evt,
    input wire nim_pkg::nim_ctx_type cpu_ctx,
    output nim_pkg::nim_stack_wr_type stack_wr,
    output nim_pkg::nim_pc_load_type pc_load,
    output logic cpu_stall,
    output logic sleep_halt,
    output logic sleep_wait,
    output logic priority_bit_hi,
    output logic priority_bit_lo
);
    localparam int N = NSRC + 1;

    generate
        if (NSRC < 1 || NSRC > nim_pkg::NIM_MAX_SRC) // R02
        begin : g_bad_nsrc
            $error("nim_manager: NSRC must lie between 1 and 13");
        end
    endgenerate

    nim_pkg::nim_state_type state_r;
    logic [2:0] push_cnt_r;
    logic [3:0] vidx_r;
    logic [1:0] elvl_r;
    logic [1:0] prio_r;
    logic [1:0] depth_r;
    logic nest_r;
    logic [2*NSRC-1:0] swpri_r;
    logic [3:0] last_vidx_r;
    logic halt_r;
    logic wait_r;
    nim_pkg::nim_ctx_type ctx_r;
    nim_pkg::nim_stack_wr_type stack_wr_r;
    nim_pkg::nim_pc_load_type pc_load_r;
    logic [31:0] prdata_r;
    logic [N-1:0] pend;
    logic [2*N-1:0] lvl_flat;
    logic [1:0] cur_lvl;
    logic block;
    logic halt_only;
    logic found;
    logic [3:0] win_idx;
    logic [1:0] win_lvl;
    logic take;
    logic [3:0] take_vidx;
    logic [1:0] take_lvl;
    logic at_done;
    logic addr_hit;
    logic apb_wr;
    logic [7:0] cc_merged;

    nim_req_latch #(
        .N(N)
    ) u_latch (
        .mclk(mclk),
        .nrst(nrst),
        .flag({irq_flag, top_level_irq}),
        .enable({irq_enable, 1'b1}),
        .clear({irq_clear, top_level_clear}),
        .pend(pend)
    );

    // the top-level slot always sits at the top level and is halt-capable
    always_comb
    begin
        lvl_flat = '0;
        lvl_flat[1:0] = nim_pkg::NIM_LVL_TOP; // R03
        for (int i = 0; i < NSRC; i++)
        begin
            lvl_flat[2*(i+1) +: 2] = nim_pkg::nim_code_to_level(swpri_r[2*i +: 2]); // R05
        end
    end

    assign cur_lvl = nim_pkg::nim_code_to_level(prio_r); // R22
    assign block = !nest_r && (depth_r != 2'h0); // R18
    assign halt_only = (state_r == nim_pkg::ST_SLEEP) && halt_r; // R15

    nim_arbiter #(
        .N(N)
    ) u_arb (
        .pend(pend),
        .lvl_flat(lvl_flat),
        .wake_cap({HALT_WAKE_MASK[NSRC-1:0], 1'b1}),
        .halt_only(halt_only),
        .block(block),
        .cur_lvl(cur_lvl),
        .found(found),
        .idx(win_idx),
        .lvl(win_lvl)
    );

    // entry is taken only at an instruction end or from sleep
    assign at_done = (state_r == nim_pkg::ST_RUN) && cpu_evt.done; // R06
    assign take = (at_done && (cpu_evt.trap || found))
        || ((state_r == nim_pkg::ST_SLEEP) && found); // R14

    always_comb
    begin
        if (at_done && cpu_evt.trap) // R03
        begin
            take_vidx = nim_pkg::NIM_VIDX_TRAP;
            take_lvl = nim_pkg::NIM_LVL_TOP;
        end
        else
        begin
            take_vidx = 4'(win_idx + nim_pkg::NIM_VIDX_TLI); // R02
            take_lvl = win_lvl;
        end
    end

    // main sequence
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= nim_pkg::ST_RSTVEC;
        end
        else
        begin
            unique case (state_r)
                nim_pkg::ST_RSTVEC:
                begin
                    state_r <= nim_pkg::ST_RUN;
                end
                nim_pkg::ST_RUN:
                begin
                    if (take)
                    begin
                        state_r <= nim_pkg::ST_PUSH;
                    end
                    else if (at_done && (cpu_evt.opcode == nim_pkg::NIM_OP_HALT || cpu_evt.wait_for_irq_instr))
                    begin
                        state_r <= nim_pkg::ST_SLEEP;
                    end
                end
                nim_pkg::ST_SLEEP:
                begin
                    if (take) // R16
                    begin
                        state_r <= nim_pkg::ST_PUSH;
                    end
                end
                nim_pkg::ST_PUSH:
                begin
                    if (push_cnt_r == nim_pkg::NIM_PUSH_LAST)
                    begin
                        state_r <= nim_pkg::ST_VECT;
                    end
                end
                nim_pkg::ST_VECT:
                begin
                    state_r <= nim_pkg::ST_RUN;
                end
            endcase
        end
    end

    // vector, level and context caught at the moment of entry
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            vidx_r <= nim_pkg::NIM_VIDX_RESET;
            elvl_r <= nim_pkg::NIM_LVL_TOP;
            ctx_r <= '0;
        end
        else if (take)
        begin
            vidx_r <= take_vidx;
            elvl_r <= take_lvl;
            ctx_r <= cpu_ctx;
        end
    end

    // stacked cc carries the live priority bits
    always_comb
    begin
        cc_merged = ctx_r.cc;
        cc_merged[nim_pkg::NIM_BIT_PHI] = prio_r[1];
        cc_merged[nim_pkg::NIM_BIT_PLO] = prio_r[0];
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            push_cnt_r <= '0;
            stack_wr_r <= '0;
        end
        else if (state_r == nim_pkg::ST_PUSH)
        begin
            push_cnt_r <= push_cnt_r + 3'h1;
            stack_wr_r.valid <= 1'b1; // R07
            unique case (push_cnt_r)
                3'h0: stack_wr_r.data <= ctx_r.pc[7:0];
                3'h1: stack_wr_r.data <= ctx_r.pc[15:8];
                3'h2: stack_wr_r.data <= ctx_r.x;
                3'h3: stack_wr_r.data <= ctx_r.a;
                default: stack_wr_r.data <= cc_merged;
            endcase
        end
        else
        begin
            push_cnt_r <= '0;
            stack_wr_r <= '0;
        end
    end

    // program counter load after stacking, and the reset vector
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pc_load_r <= '0;
        end
        else if (state_r == nim_pkg::ST_RSTVEC)
        begin
            pc_load_r.valid <= 1'b1; // R03
            pc_load_r.addr <= nim_pkg::nim_vec_addr(nim_pkg::NIM_VIDX_RESET);
        end
        else if (state_r == nim_pkg::ST_VECT)
        begin
            pc_load_r.valid <= 1'b1; // R09
            pc_load_r.addr <= nim_pkg::nim_vec_addr(vidx_r); // R04
        end
        else
        begin
            pc_load_r <= '0;
        end
    end

    // current priority bits
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            prio_r <= nim_pkg::NIM_CODE_L3;
        end
        else if (state_r == nim_pkg::ST_VECT)
        begin
            prio_r <= nim_pkg::nim_level_to_code(elvl_r); // R08
        end
        else if (at_done && !take)
        begin
            if (cpu_evt.return_from_interrupt || cpu_evt.pop_cc) // R10
            begin
                prio_r <= {cpu_evt.pop_data[nim_pkg::NIM_BIT_PHI],
                    cpu_evt.pop_data[nim_pkg::NIM_BIT_PLO]}; // R23
            end
            else if (cpu_evt.opcode == nim_pkg::NIM_OP_HALT || cpu_evt.wait_for_irq_instr || cpu_evt.unmask_interrupts_instr)
            begin
                prio_r <= nim_pkg::NIM_CODE_L0; // R20
            end
            else if (cpu_evt.sim)
            begin
                prio_r <= nim_pkg::NIM_CODE_L3; // R23
            end
        end
    end

    // nesting depth wraps silently past four levels
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            depth_r <= '0;
        end
        else if (state_r == nim_pkg::ST_VECT)
        begin
            depth_r <= depth_r + 2'h1; // R01 R21
        end
        else if (at_done && cpu_evt.return_from_interrupt && depth_r != 2'h0)
        begin
            depth_r <= depth_r - 2'h1; // R10
        end
    end

    // sleep modes
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            halt_r <= 1'b0;
            wait_r <= 1'b0;
        end
        else if (take)
        begin
            halt_r <= 1'b0; // R17
            wait_r <= 1'b0;
        end
        else if (at_done && cpu_evt.opcode == nim_pkg::NIM_OP_HALT)
        begin
            halt_r <= 1'b1; // R15
        end
        else if (at_done && cpu_evt.wait_for_irq_instr)
        begin
            wait_r <= 1'b1; // R14
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            last_vidx_r <= nim_pkg::NIM_VIDX_RESET;
        end
        else if (state_r == nim_pkg::ST_VECT)
        begin
            last_vidx_r <= vidx_r;
        end
    end

    // apb slave, zero wait states
    always_comb
    begin
        unique case (paddr)
            nim_pkg::NIM_OFS_SWPRI,
            nim_pkg::NIM_OFS_CTRL,
            nim_pkg::NIM_OFS_STAT,
            nim_pkg::NIM_OFS_VECT: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    assign apb_wr = psel && penable && pwrite && addr_hit;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            swpri_r <= {NSRC{nim_pkg::NIM_SWPRI_RST_CODE}};
            nest_r <= 1'b0;
        end
        else if (apb_wr && paddr == nim_pkg::NIM_OFS_SWPRI)
        begin
            swpri_r <= pwdata[2*NSRC-1:0];
        end
        else if (apb_wr && paddr == nim_pkg::NIM_OFS_CTRL)
        begin
            nest_r <= pwdata[nim_pkg::NIM_CTRL_NEST_BIT]; // R18
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            prdata_r <= '0;
        end
        else if (psel && !penable)
        begin
            prdata_r <= '0;
            unique case (paddr)
                nim_pkg::NIM_OFS_SWPRI: prdata_r[2*NSRC-1:0] <= swpri_r;
                nim_pkg::NIM_OFS_CTRL: prdata_r[nim_pkg::NIM_CTRL_NEST_BIT] <= nest_r;
                nim_pkg::NIM_OFS_STAT:
                begin
                    prdata_r[N-1:0] <= pend;
                    prdata_r[nim_pkg::NIM_STAT_LVL_LSB +: 2] <= cur_lvl;
                    prdata_r[nim_pkg::NIM_STAT_DEPTH_LSB +: 2] <= depth_r;
                    prdata_r[nim_pkg::NIM_STAT_HALT_BIT] <= halt_r;
                    prdata_r[nim_pkg::NIM_STAT_WAIT_BIT] <= wait_r;
                end
                nim_pkg::NIM_OFS_VECT: prdata_r[3:0] <= last_vidx_r;
                default: prdata_r <= '0;
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    assign stack_wr = stack_wr_r;
    assign pc_load = pc_load_r;
    assign cpu_stall = (state_r == nim_pkg::ST_RSTVEC) || (state_r == nim_pkg::ST_PUSH)
        || (state_r == nim_pkg::ST_VECT);
    assign sleep_halt = halt_r;
    assign sleep_wait = wait_r;
    assign priority_bit_hi = prio_r[1]; // R05
    assign priority_bit_lo = prio_r[0];
endmodule // nim_manager
`default_nettype wire

// ===== rtl/nim_pkg.sv
// nim_pkg: constants, carriers and helpers of the nested interrupt manager
// assumes one core clock and an apb master with 32-bit data
package nim_pkg;
    localparam int NIM_MAX_SRC = 13;
    localparam int NIM_BIT_PHI = 5;
    localparam int NIM_BIT_PLO = 3;
    localparam logic [15:0] NIM_VEC_TOP = 16'hfffe;
    localparam logic [15:0] NIM_VEC_BASE = 16'hffe0;
    localparam logic [3:0] NIM_VIDX_RESET = 4'h0;
    localparam logic [3:0] NIM_VIDX_TRAP = 4'h1;
    localparam logic [3:0] NIM_VIDX_TLI = 4'h2;
    localparam logic [7:0] NIM_OP_HALT = 8'h8e;
    localparam logic [1:0] NIM_CODE_L0 = 2'h2;
    localparam logic [1:0] NIM_CODE_L3 = 2'h3;
    localparam logic [1:0] NIM_LVL_TOP = 2'h3;
    localparam logic [1:0] NIM_SWPRI_RST_CODE = 2'h3;
    localparam logic [2:0] NIM_PUSH_LAST = 3'h4;
    localparam logic [7:0] NIM_OFS_SWPRI = 8'h00;
    localparam logic [7:0] NIM_OFS_CTRL = 8'h04;
    localparam logic [7:0] NIM_OFS_STAT = 8'h08;
    localparam logic [7:0] NIM_OFS_VECT = 8'h0c;
    localparam int NIM_CTRL_NEST_BIT = 0;
    localparam int NIM_STAT_LVL_LSB = 16;
    localparam int NIM_STAT_DEPTH_LSB = 20;
    localparam int NIM_STAT_HALT_BIT = 24;
    localparam int NIM_STAT_WAIT_BIT = 25;

    typedef enum logic [2:0] {ST_RSTVEC, ST_RUN, ST_SLEEP, ST_PUSH, ST_VECT} nim_state_type;

    typedef struct packed {
        logic done;
        logic [7:0] opcode;
        logic trap;
        logic unmask_interrupts_instr;
        logic sim;
        logic wait_for_irq_instr;
        logic return_from_interrupt;
        logic pop_cc;
        logic [7:0] pop_data;
    } nim_cpu_evt_type;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] x;
        logic [7:0] a;
        logic [7:0] cc;
    } nim_ctx_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } nim_stack_wr_type;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } nim_pc_load_type;

    function automatic logic [1:0] nim_code_to_level(input logic [1:0] code);
        case (code)
            2'h2: nim_code_to_level = 2'h0;
            2'h1: nim_code_to_level = 2'h1;
            2'h0: nim_code_to_level = 2'h2;
            default: nim_code_to_level = 2'h3;
        endcase
    endfunction

    function automatic logic [1:0] nim_level_to_code(input logic [1:0] lvl);
        case (lvl)
            2'h0: nim_level_to_code = 2'h2;
            2'h1: nim_level_to_code = 2'h1;
            2'h2: nim_level_to_code = 2'h0;
            default: nim_level_to_code = 2'h3;
        endcase
    endfunction

    function automatic logic [15:0] nim_vec_addr(input logic [3:0] vidx);
        nim_vec_addr = NIM_VEC_TOP - {11'h000, vidx, 1'b0};
    endfunction
endpackage

// ===== rtl/nim_req_latch.sv
// nim_req_latch: one request latch per source, index 0 is the top-level input
// assumes flags, enables and clear pulses synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module nim_req_latch #(
    parameter int N = 14
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [N-1:0] flag,
    input wire logic [N-1:0] enable,
    input wire logic [N-1:0] clear,
    output logic [N-1:0] pend
);
    logic [N-1:0] pend_r;
    logic [N-1:0] req;

    assign req = flag & enable; // R11

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pend_r <= '0;
        end
        else
        begin
            pend_r <= req | (pend_r & ~clear); // R13
        end
    end

    assign pend = pend_r;
endmodule // nim_req_latch
`default_nettype wire

// ===== tb/nim_core_model.sv
// nim_core_model: core and peripherals facing the interrupt manager
// assumes bit 13 of flags and clears is the top-level line; kind = trap,rim,sim,wfi,return_from_interrupt
`timescale 1ns/100ps
`default_nettype none
module nim_core_model (
    input wire logic mclk,
    input wire logic cpu_stall,
    input wire nim_pkg::nim_stack_wr_type stack_wr,
    output nim_pkg::nim_cpu_evt_type cpu_evt,
    output nim_pkg::nim_ctx_type cpu_ctx,
    output logic [13:0] flags,
    output logic [13:0] enables,
    output logic [13:0] clears
);
    logic [7:0] stk[$];
    initial
    begin
        cpu_evt = '0;
        cpu_ctx = {16'h1234, 8'h56, 8'h78, 8'h01};
        flags = '0;
        enables = '0;
        clears = '0;
    end
    always @(posedge mclk)
    begin
        if (stack_wr.valid) stk.push_back(stack_wr.data);
    end
    task automatic exec(input logic [7:0] op, input logic [4:0] kind);
        logic [7:0] top;
        do @(negedge mclk); while (cpu_stall);
        top = (stk.size() > 0) ? stk[$] : 8'h00;
        if (kind[0])
            repeat (5) if (stk.size() > 0) void'(stk.pop_back());
        @(posedge mclk);
        cpu_evt <= {1'b1, op, kind, op == 8'h86, top};
        @(posedge mclk);
        cpu_evt.done <= 1'b0;
    endtask
    task automatic raise(input logic [13:0] m, input logic en);
        @(posedge mclk);
        flags <= flags | m;
        if (en) enables <= enables | m;
    endtask
    task automatic clear_src(input logic [13:0] m);
        @(posedge mclk);
        flags <= flags & ~m;
        clears <= m;
        @(posedge mclk);
        clears <= '0;
    endtask
endmodule // nim_core_model
`default_nettype wire

// ===== tb/nim_manager_chk.sv
// nim_manager_chk: temporal checks on the core-side ports of the interrupt manager
// assumes one clock mclk and the asynchronous active-low reset nrst
`timescale 1ns/100ps
`default_nettype none
module nim_manager_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire nim_pkg::nim_cpu_evt_type cpu_evt,
    input wire nim_pkg::nim_stack_wr_type stack_wr,
    input wire nim_pkg::nim_pc_load_type pc_load,
    input wire logic cpu_stall,
    input wire logic sleep_halt,
    input wire logic priority_bit_hi,
    input wire logic priority_bit_lo
);
    logic [1:0] bits;
    logic evt_ok;
    assign bits = {priority_bit_hi, priority_bit_lo};
    assign evt_ok = cpu_evt.done && !cpu_evt.trap;
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    vec_window_a: assert property (pc_load.valid |-> pc_load.addr[15:5] == 11'h7ff)
        else $error("vector address outside the top window");
    push_order_a: assert property ($rose(stack_wr.valid) |-> stack_wr.valid [*5] ##1
        (!stack_wr.valid && pc_load.valid))
        else $error("push order wrong");
    push_stall_a: assert property (stack_wr.valid |-> cpu_stall)
        else $error("stack write while core not stalled");
    trap_entry_a: assert property (cpu_evt.done && cpu_evt.trap |-> ##1 cpu_stall ##6
        (pc_load.valid && pc_load.addr == 16'hfffc))
        else $error("trap not entered on time");
    trap_level_a: assert property (pc_load.valid && pc_load.addr == 16'hfffc |-> bits == 2'h3)
        else $error("trap entry level wrong");
    halt_unmask_a: assert property (evt_ok && cpu_evt.opcode == 8'h8e |=> cpu_stall || bits == 2'h2)
        else $error("halt did not unmask");
    mask_set_a: assert property (evt_ok && cpu_evt.sim |=> cpu_stall || bits == 2'h3)
        else $error("mask instruction did not mask");
    unmask_a: assert property (evt_ok && (cpu_evt.unmask_interrupts_instr || cpu_evt.wait_for_irq_instr) |=> cpu_stall || bits == 2'h2)
        else $error("unmask instruction did not unmask");
    return_from_interrupt_bits_a: assert property (evt_ok && cpu_evt.return_from_interrupt |=> cpu_stall ||
        bits == {$past(cpu_evt.pop_data[5]), $past(cpu_evt.pop_data[3])})
        else $error("return did not restore priority bits");
    bits_hold_a: assert property (!$past(cpu_evt.done) && !pc_load.valid |-> $stable(bits))
        else $error("priority bits changed without cause");
    cover property (cpu_evt.done && cpu_evt.trap);
    cover property (sleep_halt ##[1:20] pc_load.valid);
    cover property ($rose(stack_wr.valid));
endmodule // nim_manager_chk
bind nim_manager nim_manager_chk i_chk (
    .mclk(mclk), .nrst(nrst), .cpu_evt(cpu_evt), .stack_wr(stack_wr), .pc_load(pc_load),
    .cpu_stall(cpu_stall), .sleep_halt(sleep_halt), .priority_bit_hi(priority_bit_hi),
    .priority_bit_lo(priority_bit_lo)
);
`default_nettype wire

// ===== tb/test_nested_interrupt_manager.sv
// test_nested_interrupt_manager: self-checking bench of the interrupt manager
// assumes nim_core_model on the core side and the bound checker
`timescale 1ns/100ps
`default_nettype none
module test_nested_interrupt_manager;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, cpu_stall, sleep_halt, sleep_wait, bit_hi, bit_lo, err;
    logic [13:0] flags, enables, clears;
    nim_pkg::nim_cpu_evt_type cpu_evt;
    nim_pkg::nim_ctx_type cpu_ctx;
    nim_pkg::nim_stack_wr_type stack_wr;
    nim_pkg::nim_pc_load_type pc_load;
    int fails = 0;
    int checks = 0;
    always #12.5 mclk = ~mclk;
    nim_manager #(.NSRC(13), .HALT_WAKE_MASK(13'h000f)) i_dut (
        .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_flag(flags[12:0]), .irq_enable(enables[12:0]), .irq_clear(clears[12:0]),
        .top_level_irq(flags[13]), .top_level_clear(clears[13]), .cpu_evt(cpu_evt),
        .cpu_ctx(cpu_ctx), .stack_wr(stack_wr), .pc_load(pc_load), .cpu_stall(cpu_stall),
        .sleep_halt(sleep_halt), .sleep_wait(sleep_wait), .priority_bit_hi(bit_hi),
        .priority_bit_lo(bit_lo)
    );
    nim_core_model i_core (
        .mclk(mclk), .cpu_stall(cpu_stall), .stack_wr(stack_wr), .cpu_evt(cpu_evt),
        .cpu_ctx(cpu_ctx), .flags(flags), .enables(enables), .clears(clears)
    );
    task automatic print_verdict();
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic bits(input logic [1:0] code);
        @(negedge mclk);
        chk({30'h0, bit_hi, bit_lo}, {30'h0, code});
    endtask
    task automatic entry(input logic [15:0] addr, input logic [1:0] code);
        int n = 0;
        do
        begin
            @(negedge mclk);
            n++;
        end
        while (pc_load.valid !== 1'b1 && n < 20);
        chk({15'h0, pc_load.valid, pc_load.addr}, {16'h1, addr});
        chk({30'h0, bit_hi, bit_lo}, {30'h0, code});
    endtask
    task automatic quiet();
        logic seen = 1'b0;
        repeat (12)
        begin
            @(negedge mclk);
            seen = seen | pc_load.valid;
        end
        chk({31'h0, seen}, 32'h0);
    endtask
    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h03ff_ffff);
        apb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({q[30:0], err}, 32'h1);
        apb(1'b1, 8'h00, 32'h02aa_a281);
        apb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h02aa_a281);
    endtask
    task automatic t_entry();
        i_core.exec(8'h9a, 5'b01000);
        bits(2'h2);
        i_core.raise(14'h0001, 1'b0);
        i_core.exec(8'h9d, 5'b0);
        quiet();
        i_core.raise(14'h0001, 1'b1);
        i_core.exec(8'h9d, 5'b0);
        entry(16'hfff8, 2'h1);
        chk({i_core.stk[0], i_core.stk[1], i_core.stk[2], i_core.stk[3]}, 32'h3412_5678);
        chk({24'h0, i_core.stk[4]}, 32'h21);
        apb(1'b0, 8'h0c, 32'h0);
        chk(q, 32'h3);
        i_core.clear_src(14'h0001);
        i_core.exec(8'h80, 5'b00001);
        bits(2'h2);
    endtask
    task automatic t_mask();
        i_core.exec(8'h9b, 5'b00100);
        bits(2'h3);
        i_core.exec(8'h86, 5'b0);
        bits(2'h0);
        i_core.raise(14'h0002, 1'b1);
        i_core.exec(8'h9d, 5'b0);
        quiet();
        apb(1'b0, 8'h08, 32'h0);
        chk(q & 32'h4, 32'h4);
        i_core.clear_src(14'h0002);
        apb(1'b0, 8'h08, 32'h0);
        chk(q & 32'h4, 32'h0);
        i_core.exec(8'h9a, 5'b01000);
        i_core.exec(8'h9d, 5'b0);
        quiet();
    endtask
    task automatic t_rank();
        i_core.raise(14'h0007, 1'b1);
        i_core.exec(8'h9d, 5'b0);
        entry(16'hfff6, 2'h0);
        i_core.raise(14'h2000, 1'b1);
        i_core.exec(8'h9d, 5'b0);
        quiet();
        apb(1'b1, 8'h04, 32'h1);
        i_core.exec(8'h9d, 5'b0);
        entry(16'hfffa, 2'h3);
        i_core.clear_src(14'h2007);
        i_core.exec(8'h80, 5'b00001);
        bits(2'h0);
        i_core.exec(8'h80, 5'b00001);
        bits(2'h2);
    endtask
    task automatic t_trap_sleep();
        i_core.exec(8'h9b, 5'b00100);
        i_core.exec(8'h83, 5'b10000);
        entry(16'hfffc, 2'h3);
        i_core.exec(8'h80, 5'b00001);
        bits(2'h3);
        i_core.raise(14'h0020, 1'b1);
        i_core.exec(8'h8e, 5'b0);
        bits(2'h2);
        quiet();
        chk({31'h0, sleep_halt}, 32'h1);
        i_core.raise(14'h0004, 1'b1);
        entry(16'hfff4, 2'h0);
        i_core.clear_src(14'h0004);
        i_core.exec(8'h80, 5'b00001);
        i_core.exec(8'h9d, 5'b0);
        entry(16'hffee, 2'h0);
        i_core.clear_src(14'h0020);
        i_core.exec(8'h80, 5'b00001);
        i_core.exec(8'h8f, 5'b00010);
        quiet();
        chk({31'h0, sleep_wait}, 32'h1);
        i_core.raise(14'h0020, 1'b1);
        entry(16'hffee, 2'h0);
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        entry(16'hfffe, 2'h3);
        t_regs();
        t_entry();
        t_mask();
        t_rank();
        t_trap_sleep();
        print_verdict();
    end
    initial
    begin
        #200000;
        fails++;
        print_verdict();
    end
endmodule // test_nested_interrupt_manager
`default_nettype wire
